// *** src/cpsm_clock_ctrl.sv ***
`timescale 1ns/1ps
`include "cpsm_regs.svh"
// Summary of operation
// RULE1: system tick is selected source divided by fast divisor plus one
// RULE2: fast prescaler resets to 4Fh unless programming mode is strapped
// RULE3: multiplier field resets to 100, giving 48 MHz from 12 MHz
// RULE4: multiplier codes 011, 100, 101 give x3, x4, x5; others reserved
// RULE5: software keeps fast prescaler unchanged while system clock uses PLL
// RULE6: slow tick is main clock divided by two times slow divisor plus one
// RULE7: slow prescaler resets to B6h
// RULE8: one byte holds two auxiliary divisor fields, one per auxiliary clock
// RULE9: auxiliary prescaler resets to FFh
// RULE10: active uses main, power save slow clock, idle and halt no system clock
// RULE11: low-frequency oscillator stays enabled in every mode
// RULE12: in halt the slow clock stops, stopping timer and watchdog
// RULE13: oscillator on/off in save/idle only while slow clock uses low-frequency source
// RULE14: timer and watchdog clock is slow clock except in halt
// RULE15: core runs in active, may stop in save, stops in idle and halt
// RULE16: wake-up and power units keep processing events in idle and halt
// RULE17: switchable module clocks from PLL, aux one, aux two; all off in halt
// RULE18: software disables the converter before halt for lowest power
// RULE19: software disables random generator oscillators for maximum saving
// RULE20: slow clock source is the 32 kHz oscillator or divided main clock
// RULE21: slow select 0 picks prescaled main clock, 1 the 32 kHz oscillator
// RULE22: switch to PLL only when powered and stable, else main clock kept
// RULE23: each auxiliary clock runs only when enabled and main clock stable
// RULE24: auxiliary clock is main clock divided by its field plus one
// RULE25: new divisors take effect only at a period boundary, no short pulses
module cpsm_clock_ctrl
  import cpsm_pkg::*;
(
  // clock, reset, enable
  input  wire logic                SYS_CLK,
  input  wire logic                RSTN,
  input  wire logic                CLK_EN,
  // avalon-mm slave
  input  wire logic [2:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  // clock sources (ticks from on-chip oscillator logic)
  input  wire logic                MAIN_TICK,
  input  wire logic                PLL_TICK,
  input  wire logic                MAIN_STABLE,
  input  wire logic                PLL_STABLE,
  // pins from outside the domain
  input  wire logic                LF_OSC_PIN,
  input  wire logic                PROGRAMMING_MODE_MODE_PIN,
  // clock enables and oscillator controls
  output logic                     SYS_TICK,
  output logic                     CPU_TICK,
  output logic                     PERIPH_TICK,
  output logic                     SLOW_TICK,
  output logic                     TWM_TICK,
  output logic                     USB_TICK,
  output logic                     AUX1_TICK,
  output logic                     AUX2_TICK,
  output logic                     HF_OSC_EN,
  output logic                     LF_OSC_EN,
  output logic                     PLL_PWR_EN,
  output logic      [2:0]          PLL_MULT,
  output logic                     WAKE_ASYNC_EN,
  output cpsm_pkg::cpsm_mode_e     POWER_MODE
);
  import cpsm_pkg::*;

  // ---------------------------------------------------------------
  // divider step
  // ---------------------------------------------------------------
  // returns {hit, count, limit}; a new limit is only taken at terminal count
  function automatic logic [16:0] div_step(input logic [7:0] cnt, input logic [7:0] lim,
                                           input logic [7:0] new_lim, input logic tick);
    logic [16:0] r;
    r = {1'b0, cnt, lim};
    if (tick)
    begin
      if (cnt >= lim)
        r = {1'b1, 8'h00, new_lim};
      else
        r = {1'b0, 8'(cnt + 8'h01), lim};
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] lf_sync_r, lf_sync_nxt;
  logic [1:0] programming_mode_sync_r, programming_mode_sync_nxt;
  logic       lf_prev_r, lf_prev_nxt;
  logic       lf_rise;

  // two flops each; only the second stage is looked at
  always_comb
  begin
    lf_sync_nxt   = {lf_sync_r[0], LF_OSC_PIN};
    programming_mode_sync_nxt = {programming_mode_sync_r[0], PROGRAMMING_MODE_MODE_PIN};
    lf_prev_nxt   = lf_sync_r[1];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      lf_sync_r   <= 2'h0;
      lf_prev_r   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      lf_sync_r   <= lf_sync_nxt;
      lf_prev_r   <= lf_prev_nxt;
    end
  end

  // the strap synchroniser keeps running through reset, else the strap is never seen
  always_ff @(posedge SYS_CLK)
  begin
    if (CLK_EN)
      programming_mode_sync_r <= programming_mode_sync_nxt;
  end

  assign lf_rise = lf_sync_r[1] & ~lf_prev_r;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic       ack_r, ack_nxt;
  logic       wr_go;
  logic [31:0] rdata_r, rdata_nxt;
  logic [4:0] ctrl_r, ctrl_nxt;
  cpsm_byte_t fast_r, fast_nxt;
  cpsm_byte_t slow_r, slow_nxt;
  cpsm_byte_t aux_r, aux_nxt;
  cpsm_mode_e mode_r, mode_nxt;
  logic       hf_off_r, hf_off_nxt;
  logic       cpu_stop_r, cpu_stop_nxt;
  logic       usb_en_r, usb_en_nxt;
  logic       pll_ok;
  logic       halt;

  assign halt   = (mode_r == CPSM_HALT);
  assign pll_ok = ~ctrl_r[`CPSM_CTRL_PLLPD] & PLL_STABLE & ~halt;
  // one wait state: the request is decoded, then answered
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign wr_go           = AVS_WRITE & ack_r;

  // register writes and read mux
  always_comb
  begin
    ack_nxt      = (AVS_READ | AVS_WRITE) & ~ack_r;
    rdata_nxt    = rdata_r;
    ctrl_nxt     = ctrl_r;
    fast_nxt     = fast_r;
    slow_nxt     = slow_r;
    aux_nxt      = aux_r;
    mode_nxt     = mode_r;
    hf_off_nxt   = hf_off_r;
    cpu_stop_nxt = cpu_stop_r;
    usb_en_nxt   = usb_en_r;
    if (wr_go)
    begin
      case (AVS_ADDRESS)
        `CPSM_IDX_CTRL:
        begin
          ctrl_nxt[`CPSM_CTRL_SLOWSEL] = AVS_WRITEDATA[`CPSM_CTRL_SLOWSEL]; // see RULE21
          ctrl_nxt[`CPSM_CTRL_AUX1EN]  = AVS_WRITEDATA[`CPSM_CTRL_AUX1EN];
          ctrl_nxt[`CPSM_CTRL_AUX2EN]  = AVS_WRITEDATA[`CPSM_CTRL_AUX2EN];
          // leaving the main clock needs a powered, stable pll
          if (AVS_WRITEDATA[`CPSM_CTRL_FASTSRC] || pll_ok) // see RULE22
            ctrl_nxt[`CPSM_CTRL_FASTSRC] = AVS_WRITEDATA[`CPSM_CTRL_FASTSRC];
          // powering the pll down only while the main clock is the source
          if (!AVS_WRITEDATA[`CPSM_CTRL_PLLPD] || ctrl_r[`CPSM_CTRL_FASTSRC])
            ctrl_nxt[`CPSM_CTRL_PLLPD] = AVS_WRITEDATA[`CPSM_CTRL_PLLPD];
        end
        `CPSM_IDX_FAST:   fast_nxt = AVS_WRITEDATA[7:0];
        `CPSM_IDX_SLOW:   slow_nxt = AVS_WRITEDATA[7:0];
        `CPSM_IDX_AUX:    aux_nxt  = AVS_WRITEDATA[7:0]; // see RULE8
        `CPSM_IDX_POWER:
        begin
          mode_nxt     = cpsm_mode_e'(AVS_WRITEDATA[`CPSM_PWR_MODE_HI:`CPSM_PWR_MODE_LO]);
          cpu_stop_nxt = AVS_WRITEDATA[`CPSM_PWR_CPUSTOP];
          usb_en_nxt   = AVS_WRITEDATA[`CPSM_PWR_USBEN]; // see RULE17
          // oscillator may only change while the slow clock is independent of it
          if (ctrl_r[`CPSM_CTRL_SLOWSEL]) // see RULE13
            hf_off_nxt = AVS_WRITEDATA[`CPSM_PWR_HFOFF];
        end
        default: ;
      endcase
    end
    if (AVS_READ && !ack_r)
    begin
      case (AVS_ADDRESS)
        `CPSM_IDX_CTRL:   rdata_nxt = {27'h0, ctrl_r};
        `CPSM_IDX_FAST:   rdata_nxt = {24'h0, fast_r};
        `CPSM_IDX_SLOW:   rdata_nxt = {24'h0, slow_r};
        `CPSM_IDX_AUX:    rdata_nxt = {24'h0, aux_r};
        `CPSM_IDX_POWER:  rdata_nxt = {27'h0, usb_en_r, cpu_stop_r, hf_off_r, mode_r};
        `CPSM_IDX_STATUS: rdata_nxt = {29'h0, pll_ok, PLL_STABLE, MAIN_STABLE};
        default:          rdata_nxt = 32'h0;
      endcase
    end
  end

  // the fast prescaler keeps its contents through a programming-mode reset
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0;
      ctrl_r     <= `CPSM_CTRL_RST;
      slow_r     <= `CPSM_SLOW_RST; // see RULE7
      aux_r      <= `CPSM_AUX_RST; // see RULE9
      mode_r     <= CPSM_ACTIVE;
      hf_off_r   <= 1'b0;
      cpu_stop_r <= 1'b0;
      usb_en_r   <= 1'b0;
      if (!programming_mode_sync_r[1])
        fast_r <= `CPSM_FAST_RST; // see RULE2, RULE3
    end
    else if (CLK_EN)
    begin
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
      ctrl_r     <= ctrl_nxt;
      fast_r     <= fast_nxt;
      slow_r     <= slow_nxt;
      aux_r      <= aux_nxt;
      mode_r     <= mode_nxt;
      hf_off_r   <= hf_off_nxt;
      cpu_stop_r <= cpu_stop_nxt;
      usb_en_r   <= usb_en_nxt;
    end
  end

  assign AVS_READDATA = rdata_r;

  // ---------------------------------------------------------------
  // prescalers
  // ---------------------------------------------------------------
  logic [7:0] fcnt_r, fcnt_nxt, flim_r, flim_nxt;
  logic [7:0] scnt_r, scnt_nxt, slim_r, slim_nxt;
  logic [7:0] a1cnt_r, a1cnt_nxt, a1lim_r, a1lim_nxt;
  logic [7:0] a2cnt_r, a2cnt_nxt, a2lim_r, a2lim_nxt;
  logic       sphase_r, sphase_nxt;
  logic       fast_hit, slow_hit, a1_hit, a2_hit;
  logic       fast_src_tick, main_run;
  logic       aux1_on, aux2_on;

  // the fast divider counts pll edges only when the pll was accepted
  assign fast_src_tick = ctrl_r[`CPSM_CTRL_FASTSRC] ? MAIN_TICK : (PLL_TICK & pll_ok);
  assign main_run      = MAIN_TICK & ~halt & HF_OSC_EN;
  assign aux1_on       = ctrl_r[`CPSM_CTRL_AUX1EN] & MAIN_STABLE & main_run; // see RULE23
  assign aux2_on       = ctrl_r[`CPSM_CTRL_AUX2EN] & MAIN_STABLE & main_run; // see RULE23

  // limits are swapped only at terminal count, so no period is cut short
  always_comb
  begin
    {fast_hit, fcnt_nxt, flim_nxt} = div_step(fcnt_r, flim_r,
      {4'h0, fast_r[`CPSM_FAST_DIV_HI:0]}, fast_src_tick); // see RULE1, RULE25
    {slow_hit, scnt_nxt, slim_nxt} = div_step(scnt_r, slim_r, slow_r,
      main_run); // see RULE6, RULE25
    {a1_hit, a1cnt_nxt, a1lim_nxt} = div_step(a1cnt_r, a1lim_r, {4'h0, aux_r[3:0]},
      aux1_on); // see RULE24, RULE25
    {a2_hit, a2cnt_nxt, a2lim_nxt} = div_step(a2cnt_r, a2lim_r, {4'h0, aux_r[7:4]},
      aux2_on); // see RULE24, RULE25
    // two half-periods make one slow period: factor of two
    sphase_nxt = slow_hit ? ~sphase_r : sphase_r; // see RULE6
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      fcnt_r   <= 8'h00;
      flim_r   <= {4'h0, 4'hF};
      scnt_r   <= 8'h00;
      slim_r   <= `CPSM_SLOW_RST;
      a1cnt_r  <= 8'h00;
      a1lim_r  <= {4'h0, 4'hF};
      a2cnt_r  <= 8'h00;
      a2lim_r  <= {4'h0, 4'hF};
      sphase_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      fcnt_r   <= fcnt_nxt;
      flim_r   <= flim_nxt;
      scnt_r   <= scnt_nxt;
      slim_r   <= slim_nxt;
      a1cnt_r  <= a1cnt_nxt;
      a1lim_r  <= a1lim_nxt;
      a2cnt_r  <= a2cnt_nxt;
      a2lim_r  <= a2lim_nxt;
      sphase_r <= sphase_nxt;
    end
  end

  // ---------------------------------------------------------------
  // power-mode gating
  // ---------------------------------------------------------------
  logic slow_raw, sys_raw;
  logic [10:0] tick_r, tick_nxt;

  assign slow_raw = ctrl_r[`CPSM_CTRL_SLOWSEL] ? lf_rise : (slow_hit & sphase_r); // see RULE20

  // ticks are registered so the consumers see clean one-cycle enables
  always_comb
  begin
    case (mode_r)
      CPSM_ACTIVE: sys_raw = fast_hit; // see RULE10
      CPSM_SAVE:   sys_raw = slow_raw; // see RULE10
      default:     sys_raw = 1'b0; // see RULE10
    endcase
    tick_nxt[0]  = sys_raw;
    tick_nxt[1]  = sys_raw & ~(mode_r == CPSM_SAVE && cpu_stop_r); // see RULE15
    tick_nxt[2]  = sys_raw; // see RULE15
    tick_nxt[3]  = slow_raw & ~halt; // see RULE12
    tick_nxt[4]  = slow_raw & ~halt; // see RULE14
    tick_nxt[5]  = PLL_TICK & pll_ok & usb_en_r; // see RULE17
    tick_nxt[6]  = a1_hit & ~halt; // see RULE17
    tick_nxt[7]  = a2_hit & ~halt; // see RULE17
    // halt forces the oscillator off, active forces it on
    tick_nxt[8]  = halt ? 1'b0 : (mode_r == CPSM_ACTIVE) ? 1'b1 : ~hf_off_r;
    tick_nxt[9]  = ~ctrl_r[`CPSM_CTRL_PLLPD] & ~halt & tick_nxt[8];
    tick_nxt[10] = (mode_r == CPSM_IDLE) | halt; // see RULE16
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      tick_r <= 11'h100;
    else if (CLK_EN)
      tick_r <= tick_nxt;
  end

  // outputs
  assign SYS_TICK      = tick_r[0];
  assign CPU_TICK      = tick_r[1];
  assign PERIPH_TICK   = tick_r[2];
  assign SLOW_TICK     = tick_r[3];
  assign TWM_TICK      = tick_r[4];
  assign USB_TICK      = tick_r[5];
  assign AUX1_TICK     = tick_r[6];
  assign AUX2_TICK     = tick_r[7];
  assign HF_OSC_EN     = tick_r[8];
  assign PLL_PWR_EN    = tick_r[9];
  assign WAKE_ASYNC_EN = tick_r[10];
  assign LF_OSC_EN     = 1'b1; // see RULE11
  assign POWER_MODE    = mode_r;
  // reserved codes leave the pll at its x4 setting
  assign PLL_MULT = (fast_r[`CPSM_FAST_MUL_HI:`CPSM_FAST_MUL_LO] == `CPSM_MUL_X3 ||
                     fast_r[`CPSM_FAST_MUL_HI:`CPSM_FAST_MUL_LO] == `CPSM_MUL_X5)
                    ? fast_r[`CPSM_FAST_MUL_HI:`CPSM_FAST_MUL_LO] : `CPSM_MUL_X4; // see RULE4

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_switch_req;
    wr_go && AVS_ADDRESS == `CPSM_IDX_CTRL && !AVS_WRITEDATA[`CPSM_CTRL_FASTSRC] && CLK_EN;
  endsequence

  a_pll_switch_guard: assert property (s_switch_req ##0 !pll_ok |=> ctrl_r[`CPSM_CTRL_FASTSRC]) // see RULE22
    else $error("switched to pll while not ready");
  a_halt_slow_stop: assert property (halt && CLK_EN |=> !SLOW_TICK && !TWM_TICK) // see RULE12
    else $error("slow tick in halt");
  a_idle_no_sys: assert property (mode_r != CPSM_ACTIVE && mode_r != CPSM_SAVE && CLK_EN
    |=> !SYS_TICK && !CPU_TICK) // see RULE10
    else $error("system tick without clock mode");
  a_aux_gate_off: assert property (!ctrl_r[`CPSM_CTRL_AUX1EN] |-> !aux1_on) // see RULE23
    else $error("aux one counts while disabled");
  a_div_limit_hold: assert property (!fast_hit && CLK_EN |=> $stable(flim_r)) // see RULE25
    else $error("fast divisor changed mid period");
  a_bus_one_wait: assert property (AVS_READ && !ack_r && CLK_EN |=> !AVS_WAITREQUEST) // see the one wait state note at the register bus
    else $error("read not answered after one wait");
  a_slow_reset_val: assert property ($rose(RSTN) |-> slow_r == `CPSM_SLOW_RST) // see RULE7
    else $error("slow prescaler reset value wrong");
  a_hf_change_guard: assert property (!ctrl_r[`CPSM_CTRL_SLOWSEL] && CLK_EN
    |=> $stable(hf_off_r)) // see RULE13
    else $error("oscillator control changed with divided slow clock");
  a_fast_period: assert property (fast_hit && fast_src_tick && CLK_EN && flim_r == 8'h01
    ##1 (!fast_src_tick || !CLK_EN)[*2] |-> !fast_hit) // see RULE1
    else $error("fast divider hit early");
endmodule

// *** src/cpsm_pkg.sv ***
package cpsm_pkg;
  typedef enum logic [1:0] {CPSM_ACTIVE, CPSM_SAVE, CPSM_IDLE, CPSM_HALT} cpsm_mode_e;
  typedef logic [7:0] cpsm_byte_t;
endpackage

// *** src/cpsm_regs.svh ***
`ifndef CPSM_REGS_SVH
`define CPSM_REGS_SVH
// word indices on the register bus (byte address = 4 x index)
`define CPSM_IDX_CTRL      3'h0
`define CPSM_IDX_FAST      3'h1
`define CPSM_IDX_SLOW      3'h2
`define CPSM_IDX_AUX       3'h3
`define CPSM_IDX_POWER     3'h4
`define CPSM_IDX_STATUS    3'h5
// reset values
`define CPSM_FAST_RST      8'h4F
`define CPSM_SLOW_RST      8'hB6
`define CPSM_AUX_RST       8'hFF
`define CPSM_CTRL_RST      5'h06
// control word fields
`define CPSM_CTRL_SLOWSEL  0
`define CPSM_CTRL_FASTSRC  1
`define CPSM_CTRL_PLLPD    2
`define CPSM_CTRL_AUX1EN   3
`define CPSM_CTRL_AUX2EN   4
// fast prescaler fields
`define CPSM_FAST_DIV_HI   3
`define CPSM_FAST_MUL_LO   4
`define CPSM_FAST_MUL_HI   6
// power word fields
`define CPSM_PWR_MODE_LO   0
`define CPSM_PWR_MODE_HI   1
`define CPSM_PWR_HFOFF     2
`define CPSM_PWR_CPUSTOP   3
`define CPSM_PWR_USBEN     4
// multiplier codes
`define CPSM_MUL_X3        3'h3
`define CPSM_MUL_X4        3'h4
`define CPSM_MUL_X5        3'h5
`endif

// *** tb/tb_clock_prescaler_power_modes.sv ***
`timescale 1ns/1ps
`include "cpsm_regs.svh"
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module tb_clock_prescaler_power_modes;
  import cpsm_pkg::*;
  // tick vector positions
  localparam int T_SYS = 0, T_CPU = 1, T_PER = 2, T_SLOW = 3;
  localparam int T_TWM = 4, T_USB = 5, T_AUX1 = 6, T_AUX2 = 7;
  logic        sys_clk, rstn, clk_en, avs_read, avs_write, main_tick, pll_tick;
  logic        main_stable, pll_stable, lf_pin, programming_mode_pin;
  logic [2:0]  avs_address, pc;
  logic [3:0]  lc;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic        waitreq, hf_en, lf_en, pll_pwr, wake;
  logic [7:0]  tk;
  logic [2:0]  pll_mult;
  cpsm_mode_e  pmode;
  int          num_errors, cmp_count, g, c;
  cpsm_clock_ctrl DUT (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CLK_EN(clk_en), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(waitreq), .MAIN_TICK(main_tick),
    .PLL_TICK(pll_tick), .MAIN_STABLE(main_stable), .PLL_STABLE(pll_stable),
    .LF_OSC_PIN(lf_pin), .PROGRAMMING_MODE_MODE_PIN(programming_mode_pin), .SYS_TICK(tk[0]), .CPU_TICK(tk[1]),
    .PERIPH_TICK(tk[2]), .SLOW_TICK(tk[3]), .TWM_TICK(tk[4]), .USB_TICK(tk[5]),
    .AUX1_TICK(tk[6]), .AUX2_TICK(tk[7]), .HF_OSC_EN(hf_en), .LF_OSC_EN(lf_en),
    .PLL_PWR_EN(pll_pwr), .PLL_MULT(pll_mult), .WAKE_ASYNC_EN(wake), .POWER_MODE(pmode)
  );
  // ----------------------------------------
  // clock and source ticks
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // main every 2 cycles, pll every 3, low-frequency pin period 20 cycles
  always @(posedge sys_clk)
  begin
    main_tick <= ~main_tick;
    pc <= (pc == 3'h2) ? 3'h0 : pc + 3'h1;
    pll_tick <= (pc == 3'h2);
    lc <= (lc == 4'h9) ? 4'h0 : lc + 4'h1;
    if (lc == 4'h9) lf_pin <= ~lf_pin;
  end
  // ----------------------------------------
  // bus and measuring tasks
  // ----------------------------------------
  // one request held until waitrequest is sampled low, bounded by a guard
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (waitreq !== 1'b0 && k < 50);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50) `CHK(1'b0, 1'b1, "bus hang")
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
    // let the write reach the registered outputs before anyone looks at them
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 32'h0);
    `CHK(rdv[7:0], e, m)
  endtask
  // pulses of one tick over n cycles
  task automatic cnt(input int i, input int n);
    c = 0;
    repeat (n) begin @(posedge sys_clk); if (tk[i] === 1'b1) c++; end
  endtask
  // distance between pulses; the wait for the first pulse and the first gap are skipped since divisors latch at a boundary
  task automatic gap(input int i);
    int k;
    k = 0;
    repeat (3) begin g = 0; do begin @(posedge sys_clk); g++; k++; end
      while (tk[i] !== 1'b1 && k < 600); end
    if (k >= 600) g = -1;
  endtask
  task automatic do_reset(input logic p);
    rstn <= 1'b0;
    programming_mode_pin <= p;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(`CPSM_IDX_FAST, 8'h4F, "fast reset");
    rdchk(`CPSM_IDX_SLOW, 8'hB6, "slow reset");
    rdchk(`CPSM_IDX_AUX, 8'hFF, "aux reset");
    rdchk(`CPSM_IDX_CTRL, 8'h06, "ctrl reset");
    rdchk(3'h6, 8'h00, "unmapped read");
    wr(3'h7, 8'h5A);
    rdchk(3'h7, 8'h00, "unmapped write");
    `CHK(pll_mult, 3'h4, "mult reset")
    `CHK(pmode, CPSM_ACTIVE, "mode reset")
    $display("test reset done");
  endtask
  // every multiplier code, reserved ones fall back to x4
  task automatic t_mult;
    logic [2:0] e;
    for (int m = 0; m < 8; m++)
    begin
      e = (m >= 3 && m <= 5) ? m[2:0] : 3'h4;
      wr(`CPSM_IDX_FAST, {1'b0, m[2:0], 4'h2});
      `CHK(pll_mult, e, "mult code")
    end
    wr(`CPSM_IDX_FAST, 8'h42);
    gap(T_SYS);
    `CHK(g, 6, "fast divide main")
    $display("test multiplier and fast divisor done");
  endtask
  task automatic t_slow;
    wr(`CPSM_IDX_SLOW, 8'h03);
    gap(T_SLOW);
    `CHK(g, 16, "slow divide")
    gap(T_TWM);
    `CHK(g, 16, "twm from slow")
    wr(`CPSM_IDX_CTRL, 8'h07);
    gap(T_SLOW);
    `CHK(g, 20, "slow from lf osc")
    wr(`CPSM_IDX_CTRL, 8'h06);
    gap(T_SLOW);
    `CHK(g, 16, "slow back to main")
    $display("test slow clock done");
  endtask
  task automatic t_aux;
    wr(`CPSM_IDX_CTRL, 8'h1E);
    wr(`CPSM_IDX_AUX, 8'h21);
    gap(T_AUX1);
    `CHK(g, 4, "aux one divide")
    gap(T_AUX2);
    `CHK(g, 6, "aux two divide")
    main_stable <= 1'b0;
    @(posedge sys_clk);
    cnt(T_AUX1, 40);
    `CHK(c, 0, "aux stops unstable")
    main_stable <= 1'b1;
    wr(`CPSM_IDX_CTRL, 8'h06);
    cnt(T_AUX2, 40);
    `CHK(c, 0, "aux stops disabled")
    $display("test auxiliary clocks done");
  endtask
  // pll switch refused while powered down or unstable, then accepted
  task automatic t_pll;
    wr(`CPSM_IDX_CTRL, 8'h04);
    rdchk(`CPSM_IDX_CTRL, 8'h06, "pll refused pd");
    wr(`CPSM_IDX_CTRL, 8'h02);
    pll_stable <= 1'b0;
    wr(`CPSM_IDX_CTRL, 8'h00);
    rdchk(`CPSM_IDX_CTRL, 8'h02, "pll refused unstable");
    pll_stable <= 1'b1;
    wr(`CPSM_IDX_CTRL, 8'h00);
    rdchk(`CPSM_IDX_STATUS, 8'h07, "pll accepted");
    `CHK(pll_pwr, 1'b1, "pll powered")
    gap(T_SYS);
    `CHK(g, 9, "fast divide pll")
    wr(`CPSM_IDX_CTRL, 8'h04);
    rdchk(`CPSM_IDX_CTRL, 8'h00, "pd refused on pll");
    wr(`CPSM_IDX_POWER, 8'h10);
    cnt(T_USB, 30);
    `CHK(c > 0, 1'b1, "usb on pll")
    wr(`CPSM_IDX_CTRL, 8'h02);
    wr(`CPSM_IDX_CTRL, 8'h1E);
    $display("test pll switch done");
  endtask
  task automatic t_modes;
    wr(`CPSM_IDX_POWER, 8'h12);
    cnt(T_SYS, 40);
    `CHK(c, 0, "idle no system")
    cnt(T_CPU, 20);
    `CHK(c, 0, "idle cpu stopped")
    cnt(T_PER, 20);
    `CHK(c, 0, "idle periph stopped")
    gap(T_TWM);
    `CHK(g, 16, "idle twm runs")
    `CHK(wake, 1'b1, "idle wake path")
    wr(`CPSM_IDX_POWER, 8'h05);
    `CHK(hf_en, 1'b1, "hf off refused")
    wr(`CPSM_IDX_CTRL, 8'h1F);
    wr(`CPSM_IDX_POWER, 8'h05);
    `CHK(hf_en, 1'b0, "hf off accepted")
    gap(T_SYS);
    `CHK(g, 20, "save system slow")
    // converter and random-generator oscillators are off on the software side
    wr(`CPSM_IDX_POWER, 8'h13);
    `CHK(hf_en, 1'b0, "halt hf off")
    `CHK(lf_en, 1'b1, "lf always on")
    `CHK(wake, 1'b1, "halt wake path")
    cnt(T_SLOW, 50);
    `CHK(c, 0, "halt slow still")
    cnt(T_TWM, 30);
    `CHK(c, 0, "halt twm still")
    cnt(T_AUX1, 30);
    `CHK(c, 0, "halt aux still")
    wr(`CPSM_IDX_POWER, 8'h00);
    wr(`CPSM_IDX_CTRL, 8'h06);
    `CHK(hf_en, 1'b1, "active hf on")
    cnt(T_CPU, 30);
    `CHK(c > 0, 1'b1, "active cpu runs")
    $display("test power modes done");
  endtask
  // fast prescaler keeps its value over a reset taken in programming mode
  task automatic t_programming_mode;
    wr(`CPSM_IDX_FAST, 8'h33);
    // the strap must stand before reset so the synchroniser has settled
    programming_mode_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    do_reset(1'b1);
    rdchk(`CPSM_IDX_FAST, 8'h33, "programming_mode keeps fast");
    `CHK(pll_mult, 3'h3, "programming_mode keeps mult")
    do_reset(1'b0);
    rdchk(`CPSM_IDX_FAST, 8'h4F, "normal reset fast");
    $display("test programming reset done");
  endtask
  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: the tests need well under 2000 cycles, allow 60000 cycles
  initial
  begin
    #1200000;
    num_errors++;
    print_verdict;
  end
  initial
  begin
    {rstn, avs_read, avs_write, main_tick, pll_tick, lf_pin, programming_mode_pin} = 7'h0;
    {clk_en, main_stable, pll_stable} = 3'h7;
    {avs_address, pc, lc, avs_writedata} = '0;
    num_errors = 0;
    cmp_count = 0;
    do_reset(1'b0);
    t_reset;
    t_mult;
    t_slow;
    t_aux;
    t_pll;
    t_modes;
    t_programming_mode;
    print_verdict;
  end
endmodule
